// *** src/msp_defines.svh ***
// Register indices, field positions, reset values and sizes of the modem sync/preamble block.
// Assumes the APB byte address is four times the register index.
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH
// Register indices (byte address = index * 4).
`define MSP_IDX_LINE_SYNC 6'h12
`define MSP_IDX_PREAMBLE 6'h13
`define MSP_IDX_MANTISSA 6'h14
`define MSP_IDX_STATUS 6'h20
// Reset values.
`define MSP_RST_LINE_SYNC 8'h02
`define MSP_RST_PREAMBLE 8'h22
`define MSP_RST_MANTISSA 8'hF8
// Field positions in line_code_sync_cfg.
`define MSP_DCFILT_BIT 7
`define MSP_MODFMT_HI 6
`define MSP_MODFMT_LO 4
`define MSP_MANCH_BIT 3
`define MSP_SYNC_HI 2
`define MSP_SYNC_LO 0
// Field positions in preamble_spacing_exp_cfg.
`define MSP_PRE_SPARE_BIT 7
`define MSP_NUMPRE_HI 6
`define MSP_NUMPRE_LO 4
`define MSP_EXP_HI 1
`define MSP_EXP_LO 0
// Writable mask of preamble_spacing_exp_cfg: bits 3:2 are unused.
`define MSP_PREAMBLE_WMASK 8'hF3
// Modulation format code that cannot carry Manchester coding.
`define MSP_MOD_4FSK 3'h4
// Sync word lengths and allowed bit errors.
`define MSP_SYNC_SHORT 16
`define MSP_SYNC_LONG 32
`define MSP_ERR_15OF16 6'h01
`define MSP_ERR_30OF32 6'h02
// Hidden leading one of the spacing mantissa.
`define MSP_MANT_BASE 12'h100
`endif

// *** src/msp_pkg.sv ***
// Types shared by the modem sync/preamble configuration block.
// Assumes msp_defines.svh supplies all numeric constants.
package msp_pkg;
  // Sync-word qualifier settings.
  typedef enum logic [2:0] {
    MSP_SYNC_NONE = 3'b000,
    MSP_SYNC_15_16 = 3'b001,
    MSP_SYNC_16_16 = 3'b010,
    MSP_SYNC_30_32 = 3'b011,
    MSP_SYNC_CS_ONLY = 3'b100,
    MSP_SYNC_15_16_CS = 3'b101,
    MSP_SYNC_16_16_CS = 3'b110,
    MSP_SYNC_30_32_CS = 3'b111
  } msp_sync_mode_t;
  // Transmit line coder states.
  typedef enum logic [0:0] {
    MSP_TX_FIRST = 1'b0,
    MSP_TX_SECOND = 1'b1
  } msp_tx_state_t;
endpackage : msp_pkg

// *** src/msp_modem_sync_preamble.sv ***
// Modem line coding, sync-word qualifier, preamble length and channel spacing, with an APB register slave.
// Assumes all data inputs come from logic on pclk; no pin is read directly.
//
// Summary of operation
// - Manchester bit set encodes transmit data and decodes receive data; clear passes data unchanged.
// - Sync qualifier at bits 2:0, reset 010; settings 0 and 4 disable preamble/sync detection.
// - Settings 1,2,5,6 use 16-bit sync; settings 1 and 5 accept 15 of 16.
// - Settings 2 and 6 need all 16 sync bits to match.
// - Settings 3 and 7 use a 32-bit sync word, at least 30 bits matching.
// - Settings 5,6,7 also require carrier sense above threshold.
// - Setting 4 qualifies reception on carrier sense alone, without sync detection.
// - Preamble field bits 6:4, reset 010, codes map to 2,3,4,6,8,12,16,24 bytes.
// - Spacing exponent at bits 1:0 resets to 10 and scales spacing by powers of two.
// - Spacing is fxosc/2^18 times (256 + mantissa) times 2^exponent; mantissa resets F8.
// - Carrier offset from base frequency is spacing times channel number.
`timescale 1ns/10ps
`include "msp_defines.svh"

module msp_modem_sync_preamble
  import msp_pkg::*;
#(
  parameter int CHANNEL_NUMBER_W = 8
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit data path.
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  output logic tx_bit_ready,
  output logic tx_chip,
  output logic tx_chip_valid,
  // Receive data path.
  input wire logic rx_chip,
  input wire logic rx_chip_valid,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic rx_code_error,
  // Sync qualification.
  input wire logic [31:0] sync_word,
  input wire logic carrier_sense,
  input wire logic rx_restart,
  output logic sync_found,
  output logic rx_qualified,
  output logic detect_enabled,
  // Frequency, preamble and line coding settings.
  input wire logic [CHANNEL_NUMBER_W-1:0] channel_number,
  output logic [11:0] spacing_units,
  output logic [CHANNEL_NUMBER_W+11:0] carrier_offset,
  output logic [4:0] preamble_bytes,
  output logic manchester_en,
  output logic [2:0] mod_format,
  output logic dc_filter_off,
  output logic config_conflict
);

  // Counts the set bits of one word; given the XOR of two words, it counts their differing bits.
  function automatic logic [5:0] count_ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++)
    begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : count_ones

  // Maps the preamble code to a byte count.
  function automatic logic [4:0] preamble_len(input logic [2:0] code);
    logic [4:0] n;
    case (code)
      3'h0: n = 5'h02;
      3'h1: n = 5'h03;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0C;
      3'h6: n = 5'h10;
      default: n = 5'h18;
    endcase
    return n;
  endfunction : preamble_len

  logic [7:0] line_code_sync_cfg;
  logic [7:0] preamble_spacing_exp_cfg;
  logic [7:0] channel_spacing_mantissa;
  logic [5:0] reg_index;
  logic addr_ok;
  logic apb_setup;
  logic apb_write;
  logic [31:0] next_prdata;
  msp_sync_mode_t sync_mode;
  msp_tx_state_t tx_state;
  logic tx_second_chip;
  logic rx_have_first;
  logic rx_first_chip;
  logic [31:0] sync_shift;
  logic [5:0] err_short;
  logic [5:0] err_long;
  logic word_match;
  logic [11:0] next_spacing;

  // Field views of the configuration registers.
  assign sync_mode = msp_sync_mode_t'(line_code_sync_cfg[`MSP_SYNC_HI:`MSP_SYNC_LO]);
  assign manchester_en = line_code_sync_cfg[`MSP_MANCH_BIT];
  assign mod_format = line_code_sync_cfg[`MSP_MODFMT_HI:`MSP_MODFMT_LO];
  assign dc_filter_off = line_code_sync_cfg[`MSP_DCFILT_BIT];

  // Flags a setup that software was told to avoid; the coder still follows the bit.
  assign config_conflict = manchester_en && (mod_format == `MSP_MOD_4FSK);

  // APB decode: zero wait states, unaligned or unmapped addresses answer with an error.
  assign reg_index = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && ((reg_index == `MSP_IDX_LINE_SYNC) ||
    (reg_index == `MSP_IDX_PREAMBLE) || (reg_index == `MSP_IDX_MANTISSA) || (reg_index == `MSP_IDX_STATUS));
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && addr_ok && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Read multiplexer; unused upper bits read as zero.
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (reg_index)
      `MSP_IDX_LINE_SYNC: next_prdata[7:0] = line_code_sync_cfg;
      `MSP_IDX_PREAMBLE: next_prdata[7:0] = preamble_spacing_exp_cfg & `MSP_PREAMBLE_WMASK;
      `MSP_IDX_MANTISSA: next_prdata[7:0] = channel_spacing_mantissa;
      `MSP_IDX_STATUS: next_prdata[3:0] = {config_conflict, detect_enabled, carrier_sense, rx_qualified};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup phase so it is stable through the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (apb_setup)
      prdata <= (!pwrite && addr_ok) ? next_prdata : 32'h0000_0000;
  end

  // Line coding and sync qualifier register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_code_sync_cfg <= `MSP_RST_LINE_SYNC;
    else if (apb_write && reg_index == `MSP_IDX_LINE_SYNC)
      line_code_sync_cfg <= pwdata[7:0];
  end

  // Preamble and spacing exponent register; the unused bits never store.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      preamble_spacing_exp_cfg <= `MSP_RST_PREAMBLE;
    else if (apb_write && reg_index == `MSP_IDX_PREAMBLE)
      preamble_spacing_exp_cfg <= pwdata[7:0] & `MSP_PREAMBLE_WMASK;
  end

  // Channel spacing mantissa register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_spacing_mantissa <= `MSP_RST_MANTISSA;
    else if (apb_write && reg_index == `MSP_IDX_MANTISSA)
      channel_spacing_mantissa <= pwdata[7:0];
  end

  // Preamble byte count follows the field through the lookup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      preamble_bytes <= 5'h04;
    else
      preamble_bytes <= preamble_len(preamble_spacing_exp_cfg[`MSP_NUMPRE_HI:`MSP_NUMPRE_LO]);
  end

  // Spacing in units of fxosc/2^18: (256 + mantissa) shifted by the exponent.
  assign next_spacing = (`MSP_MANT_BASE + {4'h0, channel_spacing_mantissa}) <<
    preamble_spacing_exp_cfg[`MSP_EXP_HI:`MSP_EXP_LO];

  // Spacing and carrier offset are registered so downstream synthesis sees stable words.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spacing_units <= 12'h000;
      carrier_offset <= '0;
    end
    else
    begin
      spacing_units <= next_spacing;
      carrier_offset <= (CHANNEL_NUMBER_W+12)'(next_spacing * channel_number);
    end
  end

  // Transmit is ready for a new bit unless the second Manchester chip is pending.
  assign tx_bit_ready = (tx_state == MSP_TX_FIRST);

  // Transmit coder: a one becomes chips 1,0 and a zero becomes 0,1 on consecutive cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= MSP_TX_FIRST;
      tx_chip <= 1'b0;
      tx_chip_valid <= 1'b0;
      tx_second_chip <= 1'b0;
    end
    else
    begin
      case (tx_state)
        MSP_TX_FIRST:
        begin
          tx_chip_valid <= tx_bit_valid;
          if (tx_bit_valid)
          begin
            tx_chip <= tx_bit;
            tx_second_chip <= !tx_bit;
            if (manchester_en)
              tx_state <= MSP_TX_SECOND;
          end
        end
        MSP_TX_SECOND:
        begin
          tx_chip <= tx_second_chip;
          tx_chip_valid <= 1'b1;
          tx_state <= MSP_TX_FIRST;
        end
        default:
        begin
          tx_state <= MSP_TX_FIRST;
          tx_chip_valid <= 1'b0;
        end
      endcase
    end
  end

  // Receive decoder: chips pair up, 10 gives one, 01 gives zero, equal chips are a code error.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_have_first <= 1'b0;
      rx_first_chip <= 1'b0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_code_error <= 1'b0;
    end
    else
    begin
      rx_bit_valid <= 1'b0;
      rx_code_error <= 1'b0;
      if (!manchester_en || rx_restart)
      begin
        rx_have_first <= 1'b0;
        if (rx_chip_valid && !rx_restart)
        begin
          rx_bit <= rx_chip;
          rx_bit_valid <= 1'b1;
        end
      end
      else if (rx_chip_valid)
      begin
        if (!rx_have_first)
        begin
          rx_first_chip <= rx_chip;
          rx_have_first <= 1'b1;
        end
        else
        begin
          rx_have_first <= 1'b0;
          rx_bit <= rx_first_chip;
          rx_bit_valid <= (rx_first_chip != rx_chip);
          rx_code_error <= (rx_first_chip == rx_chip);
        end
      end
    end
  end

  // Received bits shift into the correlator, newest bit in the least significant place.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_shift <= 32'h0000_0000;
    else if (rx_restart)
      sync_shift <= 32'h0000_0000;
    else if (rx_bit_valid)
      sync_shift <= {sync_shift[30:0], rx_bit};
  end

  // Bit errors against the programmed word for both sync lengths.
  assign err_short = count_ones({16'h0000, sync_shift[15:0] ^ sync_word[15:0]});
  assign err_long = count_ones(sync_shift ^ sync_word);

  // Match decision per qualifier setting; carrier sense is added in the upper settings.
  always_comb
  begin
    case (sync_mode)
      MSP_SYNC_15_16: word_match = (err_short <= `MSP_ERR_15OF16);
      MSP_SYNC_16_16: word_match = (err_short == 6'h00);
      MSP_SYNC_30_32: word_match = (err_long <= `MSP_ERR_30OF32);
      MSP_SYNC_15_16_CS: word_match = (err_short <= `MSP_ERR_15OF16) && carrier_sense;
      MSP_SYNC_16_16_CS: word_match = (err_short == 6'h00) && carrier_sense;
      MSP_SYNC_30_32_CS: word_match = (err_long <= `MSP_ERR_30OF32) && carrier_sense;
      default: word_match = 1'b0;
    endcase
  end

  // Detection is active in every setting except 0 and 4.
  assign detect_enabled = (sync_mode != MSP_SYNC_NONE) && (sync_mode != MSP_SYNC_CS_ONLY);

  // Sync found pulses once when the correlator first matches after a restart.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_found <= 1'b0;
    else
      sync_found <= detect_enabled && word_match && !rx_qualified && !rx_restart && !sync_found;
  end

  // Reception qualifier: latched on sync, carrier sense alone in setting 4, always open in setting 0.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_qualified <= 1'b0;
    else if (sync_mode == MSP_SYNC_NONE)
      rx_qualified <= 1'b1;
    else if (sync_mode == MSP_SYNC_CS_ONLY)
      rx_qualified <= carrier_sense;
    else if (sync_found)
      rx_qualified <= 1'b1;
    else if (rx_restart)
      rx_qualified <= 1'b0;
  end

endmodule : msp_modem_sync_preamble

// *** testbench/msp_modem_sync_preamble_asserts.sv ***
// Concurrent checks for the modem sync/preamble block, bound to its ports.
// Assumes register contents change only through the APB writes seen here.
`timescale 1ns/10ps
module msp_modem_sync_preamble_asserts #(
  parameter int CHANNEL_NUMBER_W = 8
)
(
  // Clock, reset and APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Data paths and qualification.
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic tx_bit_ready,
  input wire logic tx_chip,
  input wire logic tx_chip_valid,
  input wire logic carrier_sense,
  input wire logic rx_restart,
  input wire logic sync_found,
  input wire logic rx_qualified,
  input wire logic detect_enabled,
  // Frequency, preamble and line coding settings.
  input wire logic [CHANNEL_NUMBER_W-1:0] channel_number,
  input wire logic [11:0] spacing_units,
  input wire logic [CHANNEL_NUMBER_W+11:0] carrier_offset,
  input wire logic [4:0] preamble_bytes,
  input wire logic manchester_en
);
  localparam logic [4:0] PRE_TBL [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
  logic [7:0] sh_line;
  logic [7:0] sh_pre;
  logic [7:0] sh_man;
  logic wr_en;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A write lands at the access edge with the low byte strobed.
  assign wr_en = psel && penable && pwrite && pstrb[0];
  // Shadow copies of the registers, so outputs can be tied to what software wrote.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_line <= 8'h02;
      sh_pre <= 8'h22;
      sh_man <= 8'hF8;
    end
    else if (wr_en)
    begin
      if (paddr == 8'h48) sh_line <= pwdata[7:0];
      if (paddr == 8'h4C) sh_pre <= pwdata[7:0] & 8'hF3;
      if (paddr == 8'h50) sh_man <= pwdata[7:0];
    end
  end
  // A Manchester bit leaves as the bit itself, then its inverse.
  sequence s_first_chip;
    tx_chip_valid && tx_chip == $past(tx_bit);
  endsequence
  sequence s_second_chip;
    tx_chip_valid && tx_chip != $past(tx_bit, 2);
  endsequence
  chk_tx_manch: assert property (tx_bit_valid && tx_bit_ready && manchester_en |=> s_first_chip ##1 s_second_chip)
    else $error("Manchester chip pair wrong.");
  chk_tx_plain: assert property (tx_bit_valid && tx_bit_ready && !manchester_en |=> s_first_chip)
    else $error("Uncoded chip wrong.");
  chk_manch_flag: assert property (manchester_en == sh_line[3])
    else $error("Manchester enable does not follow its bit.");
  chk_detect_mode: assert property (detect_enabled == (sh_line[1:0] != 2'h0))
    else $error("Detection enable wrong for the sync setting.");
  chk_no_sync_off: assert property ($stable(sh_line[2:0]) && sh_line[1:0] == 2'h0 |-> !sync_found)
    else $error("Sync found with detection off.");
  chk_cs_only: assert property ($stable(sh_line[2:0]) && sh_line[2:0] == 3'h4 && !$past(rx_restart)
    |-> rx_qualified == $past(carrier_sense))
    else $error("Carrier-only qualification wrong.");
  chk_cs_gate: assert property (sync_found && sh_line[2] |-> $past(carrier_sense))
    else $error("Sync found without carrier sense.");
  chk_pre_len: assert property ($stable(sh_pre) |-> preamble_bytes == PRE_TBL[sh_pre[6:4]])
    else $error("Preamble byte count wrong.");
  // The spacing register still holds its reset value on the first edge after release.
  chk_spacing_val: assert property ($past(presetn) && $stable(sh_pre[1:0]) && $stable(sh_man)
    |-> spacing_units == (12'h100 + sh_man) << sh_pre[1:0])
    else $error("Channel spacing wrong.");
  chk_offset_val: assert property ($stable(channel_number) && $stable(spacing_units)
    |-> carrier_offset == spacing_units * channel_number)
    else $error("Carrier offset wrong.");
endmodule : msp_modem_sync_preamble_asserts

bind msp_modem_sync_preamble msp_modem_sync_preamble_asserts #(.CHANNEL_NUMBER_W(CHANNEL_NUMBER_W)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .tx_bit, .tx_bit_valid, .tx_bit_ready, .tx_chip, .tx_chip_valid,
  .carrier_sense, .rx_restart, .sync_found, .rx_qualified, .detect_enabled, .channel_number, .spacing_units,
  .carrier_offset, .preamble_bytes, .manchester_en);

// *** testbench/tb_top.sv ***
// Self-checking bench for the modem sync/preamble block, driven over APB and its data ports.
// Assumes a zero-wait APB slave and all inputs on pclk.
`timescale 1ns/10ps
module tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, tx_bit = 1'h0;
  logic tx_bit_valid = 1'h0, rx_chip = 1'h0, rx_chip_valid = 1'h0, carrier_sense = 1'h0, rx_restart = 1'h0;
  logic [7:0] paddr = 8'h00, channel_number = 8'h01;
  logic [31:0] pwdata = 32'h0, sync_word = 32'h8E718E71, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, tx_bit_ready, tx_chip, tx_chip_valid, rx_bit, rx_bit_valid, rx_code_error;
  logic sync_found, rx_qualified, detect_enabled, manchester_en, dc_filter_off, config_conflict;
  logic [11:0] spacing_units;
  logic [19:0] carrier_offset;
  logic [31:0] prdata;
  logic apb_err = 1'h0;
  logic [4:0] preamble_bytes;
  logic [2:0] mod_format;
  int fails = 0, checks_done = 0, cyc = 0;
  int pre_tbl [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
  msp_modem_sync_preamble #(.CHANNEL_NUMBER_W(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .tx_bit, .tx_bit_valid, .tx_bit_ready, .tx_chip, .tx_chip_valid,
    .rx_chip, .rx_chip_valid, .rx_bit, .rx_bit_valid, .rx_code_error, .sync_word, .carrier_sense, .rx_restart,
    .sync_found, .rx_qualified, .detect_enabled, .channel_number, .spacing_units, .carrier_offset,
    .preamble_bytes, .manchester_en, .mod_format, .dc_filter_off, .config_conflict);
  // Free-running 20 MHz clock.
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  // Cuts a hung run short.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("Checks %0d, mismatches %0d.", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val
  // One APB transfer; read data is taken at the edge where pready is seen.
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    apb_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  // Offers one transmit bit and checks the chips that leave.
  task tx_send(input logic b, input logic man);
    tx_bit <= b;
    tx_bit_valid <= 1'h1;
    @(posedge pclk);
    tx_bit_valid <= 1'h0;
    #1 chk_val("tx first chip", {1'h1, b}, {tx_chip_valid, tx_chip});
    chk_val("tx ready", !man, tx_bit_ready);
    @(posedge pclk);
    #1 chk_val("tx second chip", man ? {1'h1, ~b} : {1'h0, b}, {tx_chip_valid, tx_chip});
    @(posedge pclk);
  endtask : tx_send
  // Sends a Manchester chip pair and checks the decoded bit or code error.
  task rx_pair(input logic a, input logic b, input logic e);
    rx_chip <= a;
    rx_chip_valid <= 1'h1;
    @(posedge pclk);
    rx_chip <= b;
    @(posedge pclk);
    rx_chip_valid <= 1'h0;
    #1 chk_val("rx valid and error", {~e, e}, {rx_bit_valid, rx_code_error});
    if (!e) chk_val("rx bit", a, rx_bit);
    @(posedge pclk);
  endtask : rx_pair
  // Feeds the sync word with the mask bits flipped in one qualifier setting and checks the outcome.
  task sync_case(input logic [2:0] m, input int n, input logic [31:0] mask, input logic cs, input logic exp);
    logic hit;
    logic [31:0] w;
    hit = 1'h0;
    w = sync_word ^ mask;
    apb(1'h1, 8'h48, {5'h0, m}, rd);
    carrier_sense <= cs;
    rx_restart <= 1'h1;
    @(posedge pclk);
    rx_restart <= 1'h0;
    for (int i = n + 3; i >= 0; i--)
    begin
      rx_chip <= w[(i > 3) ? i - 4 : 0];
      rx_chip_valid <= (i > 3);
      @(posedge pclk);
      hit = hit | (sync_found === 1'h1);
    end
    chk_val("sync found", exp, hit);
    chk_val("rx qualified", (m == 3'h0) ? 1'h1 : (m == 3'h4) ? cs : exp, rx_qualified);
    chk_val("detect enabled", m[1:0] != 2'h0, detect_enabled);
  endtask : sync_case
  // Main sequence: reset, registers, spacing sweep, line coding, sync settings.
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    chk_val("reset spacing", 32'h7E0, spacing_units);
    chk_val("reset offset", 32'h7E0, carrier_offset);
    chk_val("reset preamble bytes", 32'h4, preamble_bytes);
    apb(1'h0, 8'h48, 8'h00, rd);
    chk_val("line sync reset", 32'h02, rd);
    apb(1'h0, 8'h4C, 8'h00, rd);
    chk_val("preamble reset", 32'h22, rd);
    apb(1'h0, 8'h50, 8'h00, rd);
    chk_val("mantissa reset", 32'hF8, rd);
    chk_val("mapped read error", 32'h0, apb_err);
    apb(1'h0, 8'h40, 8'h00, rd);
    chk_val("unmapped read", 32'h0, rd);
    chk_val("unmapped read error", 32'h1, apb_err);
    apb(1'h1, 8'h4C, 8'hFF, rd);
    apb(1'h0, 8'h4C, 8'h00, rd);
    chk_val("preamble unused bits", 32'hF3, rd);
    apb(1'h1, 8'h50, 8'h05, rd);
    for (int k = 0; k < 8; k++)
    begin
      channel_number <= 8'(k + 1);
      apb(1'h1, 8'h4C, {1'h0, k[2:0], 2'h0, k[1:0]}, rd);
      repeat (2) @(posedge pclk);
      chk_val("preamble bytes", pre_tbl[k], preamble_bytes);
      chk_val("spacing units", 32'h105 << k[1:0], spacing_units);
      chk_val("carrier offset", (32'h105 << k[1:0]) * (k + 1), carrier_offset);
    end
    // Manchester on with two-level OOK, never with four-level FSK or a serial mode.
    apb(1'h1, 8'h48, 8'hBA, rd);
    chk_val("manchester enable", 1'h1, manchester_en);
    chk_val("line coding fields", 32'h16, {dc_filter_off, mod_format, config_conflict});
    tx_send(1'h1, 1'h1);
    tx_send(1'h0, 1'h1);
    rx_pair(1'h1, 1'h0, 1'h0);
    rx_pair(1'h0, 1'h1, 1'h0);
    rx_pair(1'h1, 1'h1, 1'h1);
    apb(1'h1, 8'h48, 8'h02, rd);
    tx_send(1'h1, 1'h0);
    sync_case(3'h0, 16, 32'h0, 1'h1, 1'h0);
    sync_case(3'h1, 16, 32'h1, 1'h0, 1'h1);
    sync_case(3'h2, 16, 32'h1, 1'h0, 1'h0);
    sync_case(3'h2, 16, 32'h0, 1'h0, 1'h1);
    sync_case(3'h3, 32, 32'h10001, 1'h0, 1'h1);
    sync_case(3'h3, 32, 32'h10003, 1'h0, 1'h0);
    sync_case(3'h4, 16, 32'h0, 1'h1, 1'h0);
    sync_case(3'h5, 16, 32'h0, 1'h0, 1'h0);
    sync_case(3'h6, 16, 32'h0, 1'h1, 1'h1);
    sync_case(3'h7, 32, 32'h0, 1'h1, 1'h1);
    apb(1'h0, 8'h80, 8'h00, rd);
    chk_val("status", 32'h7, rd);
    give_verdict();
  end
endmodule : tb_top
